// file: include/prio_irq_pkg.sv
// Constants, register map and state codes of the prioritising interrupt controller.
// Behaviour
// - Eight request inputs ranked by priority, input zero highest by default.
// - Inputs 0-2 bus vectored lines, 3-5 serial channels, 6 printwheel, 7 clock pulse.
// - Three bus vectored lines are optional jumper-selected request sources.
// - Controller raises pint; host acknowledges with sinta and fetches from controller.
// - On acknowledge the Call opcode is driven as the first response byte.
// - The next two host fetches receive the 16-bit vector address.
// - Eight vectors, one per input; the acknowledged input's vector is supplied.
// - Vectors are spaced eight or four bytes apart in a 64K space.
// - Edge mode reacts to rising input edges; level mode reacts to input level.
// - Single master controller only; no cascading.
// - No buffered mode and no transceiver enable output.
// - Acknowledge sets in-service; cleared by end-of-service or auto after third byte.
// - Automatic end-of-service is chosen only during initialisation.
// - Automatic end-of-service gives no nesting since flags clear after the third byte.
// - Poll mode stops interrupt raising and waits for poll commands.
// - Poll byte: top bit pending, low three bits highest pending input.
// - Nested mode interrupts only if nothing higher is requesting or in service.
// - Higher-priority request interrupts a lower-priority service in progress.
// - Rotating mode drops the serviced input to lowest priority.
// - Eight-bit software mask blocks matching inputs from interrupting.
// - Request register ignores mask; highest pending bit clears on acknowledge in edge mode.
// - Readable in-service register cleared by specific or non-specific end-of-service.
`default_nettype none
package prio_irq_pkg;
  localparam int unsigned NUM_IN = 8;
  localparam int unsigned ADDR_W = 8;
  // Register byte addresses.
  localparam logic [7:0] ADDR_CTRL  = 8'h00;
  localparam logic [7:0] ADDR_VEC   = 8'h04;
  localparam logic [7:0] ADDR_MASK  = 8'h08;
  localparam logic [7:0] ADDR_REQ   = 8'h0C;
  localparam logic [7:0] ADDR_INSVC = 8'h10;
  localparam logic [7:0] ADDR_EOS   = 8'h14;
  localparam logic [7:0] ADDR_POLL  = 8'h18;
  localparam logic [7:0] ADDR_STAT  = 8'h1C;
  // Control register fields.
  localparam int unsigned CTRL_LEVEL    = 0;
  localparam int unsigned CTRL_SPACE4   = 1;
  localparam int unsigned CTRL_AUTO_EOS = 2;
  localparam int unsigned CTRL_POLL     = 3;
  localparam int unsigned CTRL_ROTATE   = 4;
  localparam int unsigned CTRL_INIT     = 7;
  localparam logic [7:0] CTRL_FIELDS = 8'h1F;
  localparam logic [7:0] CTRL_RESET  = 8'h03;
  localparam logic [15:0] VEC_RESET  = 16'h0000;
  localparam logic [7:0] MASK_RESET  = 8'h00;
  // End-of-service command fields.
  localparam int unsigned EOS_SPECIFIC = 3;
  // Vector low byte layout for each spacing.
  localparam logic [7:0] VEC4_KEEP  = 8'hE0;
  localparam logic [7:0] VEC8_KEEP  = 8'hC0;
  localparam int unsigned VEC4_SHIFT = 2;
  localparam int unsigned VEC8_SHIFT = 3;
  // Response bytes.
  localparam logic [7:0] CALL_OPCODE = 8'hCD;
  localparam logic [7:0] IDLE_BYTE   = 8'h00;
  localparam int unsigned POLL_VALID = 7;
  localparam logic [2:0] SPURIOUS_IN = 3'h7;
  // Bus responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Acknowledge sequence states.
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_CALL = 4'h2,
    ST_LOW  = 4'h4,
    ST_HIGH = 4'h8
  } ack_state_e;
endpackage
`default_nettype wire

// file: tb/host_cpu_model.sv
// Host processor model that answers the controller's interrupt request with an acknowledge and two fetches.
`timescale 1ns/100ps
`default_nettype none
module host_cpu_model (
  input  wire logic       clk,
  input  wire logic [7:0] ack_req,
  input  wire logic       slow,
  input  wire logic       pint,
  input  wire logic [7:0] data_in_bus,
  input  wire logic       data_in_oe,
  output logic            sinta,
  output logic            fetch_strobe,
  output logic [23:0]     got,
  output logic            oe_fault,
  output logic [7:0]      seq_cnt
);
  // Drives both host lines right after an edge and holds them for n cycles.
  task automatic hold(input logic s, input logic f, input int n);
    sinta <= s;
    fetch_strobe <= f;
    repeat (n) @(posedge clk);
  endtask

  // One acknowledge per request from the bench, captured byte by byte while the controller drives.
  initial begin
    sinta = 1'b0;
    fetch_strobe = 1'b0;
    got = '0;
    oe_fault = 1'b0;
    seq_cnt = '0;
    forever begin
      @(posedge clk);
      if (seq_cnt != ack_req && pint) begin
        hold(1'b0, 1'b0, slow ? 20 : 1);
        hold(1'b1, 1'b0, 6);
        got[7:0] = data_in_bus;
        oe_fault = oe_fault | !data_in_oe;
        hold(1'b0, 1'b0, 4);
        hold(1'b0, 1'b1, 6);
        got[15:8] = data_in_bus;
        oe_fault = oe_fault | !data_in_oe;
        hold(1'b0, 1'b0, 4);
        hold(1'b0, 1'b1, 6);
        got[23:16] = data_in_bus;
        oe_fault = oe_fault | !data_in_oe;
        hold(1'b0, 1'b0, 6);
        oe_fault = oe_fault | data_in_oe;
        // A plain fetch outside the sequence must find the bus released.
        hold(1'b0, 1'b1, 6);
        oe_fault = oe_fault | data_in_oe;
        hold(1'b0, 1'b0, 6);
        seq_cnt = seq_cnt + 8'h01;
      end
    end
  end
endmodule // host_cpu_model
`default_nettype wire

// file: tb/priority_interrupt_vectoring_bench.sv
// Self-checking bench for the prioritising interrupt controller.
`timescale 1ns/100ps
`default_nettype none
module priority_interrupt_vectoring_bench;
  import prio_irq_pkg::*;
  logic        clk = 1'b0, rst_b = 1'b0, slow = 1'b0, sinta, fetch_strobe, pint, data_in_oe, oe_fault;
  logic [7:0]  irq_pin = '0, data_in_bus, ack_req = '0, seq_cnt, s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [23:0] got;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  int          num_errors = 0, n_compared = 0;

  always #2.5 clk = ~clk;

  prio_irq_ctrl prio_irq_ctrl_i (.clk(clk), .rst_b(rst_b), .irq_pin(irq_pin), .sinta(sinta),
    .fetch_strobe(fetch_strobe), .pint(pint), .data_in_bus(data_in_bus), .data_in_oe(data_in_oe),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

  host_cpu_model host_cpu_model_i (.clk(clk), .ack_req(ack_req), .slow(slow), .pint(pint),
    .data_in_bus(data_in_bus), .data_in_oe(data_in_oe), .sinta(sinta), .fetch_strobe(fetch_strobe),
    .got(got), .oe_fault(oe_fault), .seq_cnt(seq_cnt));

  // -----------------------------------------------------------------
  // Bus tasks and comparison
  // -----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Write with address and data offered together, each released when taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 1000);
    if (!s_axi_bvalid) num_errors++;
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(er));
    @(posedge clk);
  endtask

  // Read one word and compare data and response.
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    int n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 1000);
    if (!s_axi_rvalid) num_errors++;
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, exp);
    chk(32'(s_axi_rresp), 32'(er));
    @(posedge clk);
  endtask

  // Lets the request pins pass the synchronisers.
  task automatic settle();
    repeat (6) @(posedge clk);
  endtask

  // Has the host take one acknowledge and checks the three bytes it fetched.
  task automatic ack(input logic [7:0] lo, input logic [7:0] hi);
    int n = 0;
    ack_req <= ack_req + 8'h01;
    do begin
      @(posedge clk);
      n++;
    end while (seq_cnt != ack_req && n < 500);
    chk(32'(seq_cnt), 32'(ack_req));
    chk(32'(got), {8'h00, hi, lo, CALL_OPCODE});
  endtask

  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // -----------------------------------------------------------------
  // Test sequence
  // -----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd(ADDR_CTRL, 32'h03, RESP_OKAY);
    rd(ADDR_MASK, 32'h00, RESP_OKAY);
    rd(ADDR_REQ, 32'h00, RESP_OKAY);
    rd(ADDR_INSVC, 32'h00, RESP_OKAY);
    rd(ADDR_STAT, 32'hE1, RESP_OKAY);
    rd(8'h20, 32'h00, RESP_SLVERR);
    wr(ADDR_REQ, 32'hFF, RESP_SLVERR);
    wr(ADDR_VEC, 32'h1234, RESP_OKAY);
    rd(ADDR_VEC, 32'h1234, RESP_OKAY);
    irq_pin <= 8'h28;
    settle();
    chk(32'(pint), 32'h1);
    ack(8'h2C, 8'h12);
    irq_pin <= 8'h20;
    rd(ADDR_INSVC, 32'h08, RESP_OKAY);
    chk(32'(pint), 32'h0);
    irq_pin <= 8'h22;
    settle();
    chk(32'(pint), 32'h1);
    ack(8'h24, 8'h12);
    rd(ADDR_INSVC, 32'h0A, RESP_OKAY);
    irq_pin <= 8'h20;
    wr(ADDR_EOS, 32'h00, RESP_OKAY);
    rd(ADDR_INSVC, 32'h08, RESP_OKAY);
    wr(ADDR_EOS, 32'h0B, RESP_OKAY);
    rd(ADDR_INSVC, 32'h00, RESP_OKAY);
    settle();
    ack(8'h34, 8'h12);
    wr(ADDR_EOS, 32'h0D, RESP_OKAY);
    irq_pin <= 8'h02;
    wr(ADDR_MASK, 32'h02, RESP_OKAY);
    settle();
    chk(32'(pint), 32'h0);
    rd(ADDR_REQ, 32'h02, RESP_OKAY);
    wr(ADDR_MASK, 32'h00, RESP_OKAY);
    settle();
    chk(32'(pint), 32'h1);
    irq_pin <= 8'h40;
    wr(ADDR_CTRL, 32'h09, RESP_OKAY);
    settle();
    chk(32'(pint), 32'h0);
    rd(ADDR_POLL, 32'h86, RESP_OKAY);
    rd(ADDR_INSVC, 32'h40, RESP_OKAY);
    irq_pin <= 8'h00;
    wr(ADDR_CTRL, 32'h85, RESP_OKAY);
    wr(ADDR_CTRL, 32'h01, RESP_OKAY);
    rd(ADDR_CTRL, 32'h05, RESP_OKAY);
    rd(ADDR_INSVC, 32'h00, RESP_OKAY);
    irq_pin <= 8'h04;
    settle();
    ack(8'h10, 8'h12);
    irq_pin <= 8'h00;
    rd(ADDR_INSVC, 32'h00, RESP_OKAY);
    wr(ADDR_CTRL, 32'h93, RESP_OKAY);
    irq_pin <= 8'h03;
    settle();
    ack(8'h20, 8'h12);
    wr(ADDR_EOS, 32'h00, RESP_OKAY);
    slow <= 1'b1;
    settle();
    ack(8'h24, 8'h12);
    slow <= 1'b0;
    irq_pin <= 8'h00;
    wr(ADDR_EOS, 32'h00, RESP_OKAY);
    wr(ADDR_CTRL, 32'h82, RESP_OKAY);
    irq_pin <= 8'h10;
    settle();
    ack(8'h30, 8'h12);
    wr(ADDR_EOS, 32'h00, RESP_OKAY);
    settle();
    chk(32'(pint), 32'h0);
    irq_pin <= 8'h00;
    settle();
    irq_pin <= 8'h10;
    settle();
    chk(32'(pint), 32'h1);
    chk(32'(oe_fault), 32'h0);
    finish_test();
  end

  // Cuts a hang short well beyond the expected run length.
  initial begin
    #100000;
    num_errors++;
    finish_test();
  end
endmodule // priority_interrupt_vectoring_bench
`default_nettype wire

// file: verilog/prio_irq_ctrl.sv
// Eight-input prioritising interrupt controller with an AXI4-Lite register slave.
`timescale 1ns/100ps
`default_nettype none
module prio_irq_ctrl (
  input  wire logic                              clk,
  input  wire logic                              rst_b,
  input  wire logic [prio_irq_pkg::NUM_IN-1:0]   irq_pin,
  input  wire logic                              sinta,
  input  wire logic                              fetch_strobe,
  output logic                                   pint,
  output logic [7:0]                             data_in_bus,
  output logic                                   data_in_oe,
  input  wire logic [prio_irq_pkg::ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                              s_axi_awvalid,
  output logic                                   s_axi_awready,
  input  wire logic [31:0]                       s_axi_wdata,
  input  wire logic [3:0]                        s_axi_wstrb,
  input  wire logic                              s_axi_wvalid,
  output logic                                   s_axi_wready,
  output logic [1:0]                             s_axi_bresp,
  output logic                                   s_axi_bvalid,
  input  wire logic                              s_axi_bready,
  input  wire logic [prio_irq_pkg::ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                              s_axi_arvalid,
  output logic                                   s_axi_arready,
  output logic [31:0]                            s_axi_rdata,
  output logic [1:0]                             s_axi_rresp,
  output logic                                   s_axi_rvalid,
  input  wire logic                              s_axi_rready
);
  import prio_irq_pkg::*;

  // Finds the highest-priority set bit; priority starts just above low.
  function automatic logic [3:0] top_of(input logic [7:0] v, input logic [2:0] low);
    logic [3:0] r;
    logic [2:0] idx;
    r = 4'h0;
    for (int p = NUM_IN - 1; p >= 0; p--) begin
      idx = low + 3'(p) + 3'h1;
      if (v[idx]) begin
        r = {1'b1, idx};
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [7:0]  irq_m;
  logic [7:0]  irq_s;
  logic [7:0]  irq_d;
  logic        sinta_m;
  logic        sinta_s;
  logic        sinta_d;
  logic        fetch_m;
  logic        fetch_s;
  logic        fetch_d;
  logic        sinta_rise;
  logic        sinta_fall;
  logic        fetch_fall;

  // Every pin passes two flops before any decision looks at it.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_m   <= 8'h00;
      irq_s   <= 8'h00;
      sinta_m <= 1'b0;
      sinta_s <= 1'b0;
      fetch_m <= 1'b0;
      fetch_s <= 1'b0;
    end else begin
      irq_m   <= irq_pin;
      irq_s   <= irq_m;
      sinta_m <= sinta;
      sinta_s <= sinta_m;
      fetch_m <= fetch_strobe;
      fetch_s <= fetch_m;
    end
  end

  // Delayed copies of the synchronised levels for edge detection.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_d   <= 8'h00;
      sinta_d <= 1'b0;
      fetch_d <= 1'b0;
    end else begin
      irq_d   <= irq_s;
      sinta_d <= sinta_s;
      fetch_d <= fetch_s;
    end
  end

  // Strobe edges of the host's acknowledge and fetch cycles.
  assign sinta_rise = sinta_s & ~sinta_d;
  assign sinta_fall = ~sinta_s & sinta_d;
  assign fetch_fall = ~fetch_s & fetch_d;

  // ----------------------------------------------------------------
  // Register bus slave
  // ----------------------------------------------------------------
  logic [7:0]  ctrl;
  logic [7:0]  next_ctrl;
  logic [15:0] vec_base;
  logic [7:0]  mask;
  logic [7:0]  pending_request_register;
  logic [7:0]  in_service_register;
  logic [7:0]  next_irr;
  logic [7:0]  next_isr;
  logic [2:0]  low_prio;
  logic [2:0]  next_low;
  logic [2:0]  cur_num;
  logic [2:0]  eos_num;
  ack_state_e  state;
  logic        wr_go;
  logic        rd_go;
  logic        wr_ok;
  logic        init_go;
  logic        eos_go;
  logic        poll_go;
  logic        ack_go;
  logic        auto_done;
  logic [31:0] rd_word;
  logic        rd_ok;
  logic [3:0]  top_p;
  logic [3:0]  top_s;
  logic [2:0]  rank_p;
  logic [2:0]  rank_s;
  logic        nest_ok;
  logic [7:0]  vec_lo;

  // Address and data are taken together; one write response is open at a time.
  assign wr_go         = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign rd_go         = s_axi_arvalid & ~s_axi_rvalid;
  assign s_axi_arready = ~s_axi_rvalid;

  // Writable addresses answer OKAY; all others answer SLVERR and store nothing.
  always_comb begin
    if (s_axi_awaddr == ADDR_CTRL) begin
      wr_ok = 1'b1;
    end else if (s_axi_awaddr == ADDR_VEC) begin
      wr_ok = 1'b1;
    end else if (s_axi_awaddr == ADDR_MASK) begin
      wr_ok = 1'b1;
    end else if (s_axi_awaddr == ADDR_EOS) begin
      wr_ok = 1'b1;
    end else begin
      wr_ok = 1'b0;
    end
  end

  // Command strobes decoded from accepted writes and reads.
  assign init_go = wr_go & s_axi_wstrb[0] & (s_axi_awaddr == ADDR_CTRL) & s_axi_wdata[CTRL_INIT];
  assign eos_go  = wr_go & s_axi_wstrb[0] & (s_axi_awaddr == ADDR_EOS);
  assign poll_go = rd_go & (s_axi_araddr == ADDR_POLL);

  // The auto flag keeps its value unless the write starts an initialisation.
  always_comb begin
    next_ctrl = s_axi_wdata[7:0] & CTRL_FIELDS;
    if (!s_axi_wdata[CTRL_INIT]) begin
      next_ctrl[CTRL_AUTO_EOS] = ctrl[CTRL_AUTO_EOS];
    end
  end

  // Configuration registers written by software.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl     <= CTRL_RESET;
      vec_base <= VEC_RESET;
      mask     <= MASK_RESET;
    end else if (wr_go) begin
      if (s_axi_awaddr == ADDR_CTRL && s_axi_wstrb[0]) begin
        ctrl <= next_ctrl;
      end else if (s_axi_awaddr == ADDR_VEC) begin
        if (s_axi_wstrb[0]) begin
          vec_base[7:0] <= s_axi_wdata[7:0];
        end
        if (s_axi_wstrb[1]) begin
          vec_base[15:8] <= s_axi_wdata[15:8];
        end
      end else if (s_axi_awaddr == ADDR_MASK && s_axi_wstrb[0]) begin
        mask <= s_axi_wdata[7:0];
      end
      if (init_go) begin
        mask <= MASK_RESET;
      end
    end
  end

  // Write response channel.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read data selection; the poll word is computed from the live pending state.
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_ok   = 1'b1;
    if (s_axi_araddr == ADDR_CTRL) begin
      rd_word[7:0] = ctrl;
    end else if (s_axi_araddr == ADDR_VEC) begin
      rd_word[15:0] = vec_base;
    end else if (s_axi_araddr == ADDR_MASK) begin
      rd_word[7:0] = mask;
    end else if (s_axi_araddr == ADDR_REQ) begin
      rd_word[7:0] = pending_request_register;
    end else if (s_axi_araddr == ADDR_INSVC) begin
      rd_word[7:0] = in_service_register;
    end else if (s_axi_araddr == ADDR_POLL) begin
      rd_word[POLL_VALID] = top_p[3];
      rd_word[2:0]        = top_p[2:0];
    end else if (s_axi_araddr == ADDR_STAT) begin
      rd_word[3:0] = state;
      rd_word[4]   = pint;
      rd_word[7:5] = low_prio;
    end else begin
      rd_ok = 1'b0;
    end
  end

  // Read data channel.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Priority resolution
  // ----------------------------------------------------------------
  // Ranks are distances from the top slot; rank zero is the highest priority.
  assign top_p  = top_of(pending_request_register & ~mask, low_prio);
  assign top_s  = top_of(in_service_register, low_prio);
  assign rank_p = top_p[2:0] - low_prio - 3'h1;
  assign rank_s = top_s[2:0] - low_prio - 3'h1;
  assign nest_ok = ~top_s[3] | (rank_p < rank_s);

  // Sole master of the interrupt line; silent in poll mode and during a sequence.
  assign pint = top_p[3] & nest_ok & ~ctrl[CTRL_POLL] & (state == ST_IDLE);

  assign ack_go    = sinta_rise & (state == ST_IDLE);
  assign auto_done = (state == ST_HIGH) & fetch_fall & ctrl[CTRL_AUTO_EOS];
  assign eos_num   = s_axi_wdata[EOS_SPECIFIC] ? s_axi_wdata[2:0] : top_s[2:0];

  // Request, in-service and rotation updates; input sets win over clears.
  always_comb begin
    next_irr = pending_request_register;
    next_isr = in_service_register;
    next_low = low_prio;
    if (init_go) begin
      next_irr = 8'h00;
      next_isr = 8'h00;
      next_low = SPURIOUS_IN;
    end
    if (eos_go && (s_axi_wdata[EOS_SPECIFIC] || top_s[3])) begin
      next_isr[eos_num] = 1'b0;
      if (ctrl[CTRL_ROTATE]) begin
        next_low = eos_num;
      end
    end
    if (auto_done) begin
      next_isr[cur_num] = 1'b0;
      if (ctrl[CTRL_ROTATE]) begin
        next_low = cur_num;
      end
    end
    if ((ack_go | poll_go) && top_p[3]) begin
      next_irr[top_p[2:0]] = 1'b0;
      next_isr[top_p[2:0]] = 1'b1;
    end
    if (ctrl[CTRL_LEVEL]) begin
      next_irr = irq_s;
    end else begin
      next_irr = next_irr | (irq_s & ~irq_d);
    end
  end

  // Flag registers.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pending_request_register      <= 8'h00;
      in_service_register      <= 8'h00;
      low_prio <= SPURIOUS_IN;
    end else begin
      pending_request_register      <= next_irr;
      in_service_register      <= next_isr;
      low_prio <= next_low;
    end
  end

  // ----------------------------------------------------------------
  // Acknowledge sequence
  // ----------------------------------------------------------------
  // Vector low byte: base bits above the input number, zeros below.
  always_comb begin
    if (ctrl[CTRL_SPACE4]) begin
      vec_lo = (vec_base[7:0] & VEC4_KEEP) | (8'(cur_num) << VEC4_SHIFT);
    end else begin
      vec_lo = (vec_base[7:0] & VEC8_KEEP) | (8'(cur_num) << VEC8_SHIFT);
    end
  end

  // Call opcode on acknowledge, then vector low and high byte on counted fetches.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state       <= ST_IDLE;
      cur_num     <= 3'h0;
      data_in_bus <= IDLE_BYTE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (ack_go) begin
            state       <= ST_CALL;
            cur_num     <= top_p[3] ? top_p[2:0] : SPURIOUS_IN;
            data_in_bus <= CALL_OPCODE;
          end
        end
        ST_CALL: begin
          if (sinta_fall) begin
            state       <= ST_LOW;
            data_in_bus <= vec_lo;
          end
        end
        ST_LOW: begin
          if (fetch_fall) begin
            state       <= ST_HIGH;
            data_in_bus <= vec_base[15:8];
          end
        end
        ST_HIGH: begin
          if (fetch_fall) begin
            state       <= ST_IDLE;
            data_in_bus <= IDLE_BYTE;
          end
        end
        default: begin
          state       <= ST_IDLE;
          data_in_bus <= IDLE_BYTE;
        end
      endcase
    end
  end

  // Drive only while the host is reading a counted byte; no transceiver enable exists.
  assign data_in_oe = (state == ST_CALL) |
                      (((state == ST_LOW) | (state == ST_HIGH)) & fetch_s);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_ack_start;
    (state == ST_IDLE) && sinta_rise;
  endsequence

  sequence s_call_on;
    (state == ST_CALL) && data_in_oe && (data_in_bus == CALL_OPCODE);
  endsequence

  sequence s_low_on;
    (state == ST_LOW) && (data_in_bus == vec_lo);
  endsequence

  a_call_on_ack: assert property (s_ack_start |-> ##1 s_call_on)
    else $error("Call opcode not driven after acknowledge.");

  a_vector_low: assert property ((state == ST_CALL) && sinta_fall |-> ##1 s_low_on)
    else $error("Vector low byte not presented after the call byte.");

  a_vector_high: assert property ((state == ST_LOW) && fetch_fall |=>
    (state == ST_HIGH) && (data_in_bus == vec_base[15:8]))
    else $error("Vector high byte not presented after the low byte.");

  a_bus_release: assert property ((state == ST_HIGH) && fetch_fall |=>
    !data_in_oe && (state == ST_IDLE))
    else $error("Data bus not released after the last vector byte.");

  a_idle_quiet: assert property ((state == ST_IDLE) |-> !data_in_oe)
    else $error("Data bus driven outside an acknowledge sequence.");

  a_ack_service: assert property (s_ack_start and top_p[3] |=> in_service_register[cur_num])
    else $error("Acknowledged input not marked in service.");

  a_auto_clear: assert property (auto_done |=> !in_service_register[$past(cur_num)])
    else $error("In-service flag kept after automatic end of service.");

  a_poll_silent: assert property (ctrl[CTRL_POLL] |-> !pint)
    else $error("Interrupt raised while in poll mode.");

  a_mask_gate: assert property (pint |-> ((pending_request_register & ~mask) != 8'h00))
    else $error("Interrupt raised with no unmasked request.");

  a_nested_gate: assert property (pint && top_s[3] |-> rank_p < rank_s)
    else $error("Interrupt raised below an input in service.");

endmodule // prio_irq_ctrl
`default_nettype wire
